// ---- bench/csc_far_model.sv ----
// Far-side model: frame transmitter and working settings holder
`timescale 1ns/1ps
module csc_far_model (
	input wire logic clk,
	input wire logic resetn,
	input wire logic frame_req,
	input wire logic [7:0] delay,
	input wire logic load_v,
	input wire logic [31:0] load_d,
	input wire logic set_en,
	input wire logic [31:0] set_val,
	output logic frame_done,
	output logic [31:0] cfg_work
);
	int cnt;

	always @(posedge clk) begin
		frame_done <= 1'b0;
		if (!resetn) begin
			cnt <= 0;
			cfg_work <= 32'h0;
		end else begin
			// Frame ends after a chosen number of cycles
			if (frame_req)
				cnt <= int'(delay) + 1;
			else if (cnt > 1)
				cnt <= cnt - 1;
			else if (cnt == 1) begin
				cnt <= 0;
				frame_done <= 1'b1;
			end
			if (load_v)
				cfg_work <= load_d;
			else if (set_en)
				cfg_work <= set_val;
		end
	end
endmodule

// ---- bench/tb.sv ----
// Testbench: register access, streaming, single frame, slot save and load
`timescale 1ns/1ps
module tb;
	import csc_pkg::*;
	localparam logic [31:0] DEF = 32'h5a5a0000;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [11:0] awaddr = 12'h0;
	logic [11:0] araddr = 12'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [2:0] fmt = 3'h0;
	logic set_en = 1'b0;
	logic [31:0] set_val = 32'h0;
	logic [7:0] dly = 8'h1;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, cfg_work, load_d;
	logic frame_done, stream_en, frame_req, load_v;
	int fails = 0;
	int compares = 0;
	int nfr = 0;
	int nld = 0;

	always #2.5 clk = ~clk;

	csc_ctrl #(.CFG_W(32), .CFG_DEFAULT(DEF)) dut_u (
		.clk(clk), .resetn(resetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .video_format(fmt),
		.frame_done(frame_done), .cfg_work(cfg_work),
		.stream_en(stream_en), .frame_req(frame_req),
		.cfg_load_valid(load_v), .cfg_load_data(load_d)
	);

	csc_far_model far_u (
		.clk(clk), .resetn(resetn), .frame_req(frame_req),
		.delay(dly), .load_v(load_v), .load_d(load_d),
		.set_en(set_en), .set_val(set_val),
		.frame_done(frame_done), .cfg_work(cfg_work)
	);

	always @(posedge clk) begin
		if (frame_req === 1'b1)
			nfr++;
		if (load_v === 1'b1)
			nld++;
	end

	////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				chk("bresp", {30'h0, er}, {30'h0, bresp});
				done = 1'b1;
			end
		end
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				chk("rdata", ed, rdata);
				chk("rresp", {30'h0, er}, {30'h0, rresp});
				done = 1'b1;
			end
		end
	endtask

	task complete_run;
		if (fails == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		complete_run();
	end

	initial begin
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		rd(CSC_OFS_CONT, 32'h0, CSC_RESP_OKAY);
		rd(CSC_OFS_SINGLE, 32'h0, CSC_RESP_OKAY);
		rd(CSC_OFS_SAVE_SLOT, 32'h1, CSC_RESP_OKAY);
		rd(CSC_OFS_LOAD_SLOT, 32'h0, CSC_RESP_OKAY);
		rd(12'h628, 32'h0, CSC_RESP_SLVERR);
		wr(12'h62c, 32'h1, CSC_RESP_SLVERR);
		// Streaming only in the two allowed formats
		for (int f = 0; f < 8; f++) begin
			fmt <= 3'(f);
			wr(CSC_OFS_CONT, 32'h1, CSC_RESP_OKAY);
			rd(CSC_OFS_CONT, 32'h1, CSC_RESP_OKAY);
			chk("stream_on", {31'h0, f == 0 || f == 7}, {31'h0, stream_en});
			wr(CSC_OFS_CONT, 32'h0, CSC_RESP_OKAY);
			repeat (2) @(posedge clk);
			chk("stream_off", 32'h0, {31'h0, stream_en});
		end
		// Single frame, prompt and slow transmitter, unused bits set
		for (int i = 0; i < 2; i++) begin
			dly <= i ? 8'd40 : 8'd1;
			nfr = 0;
			wr(CSC_OFS_SINGLE, 32'hffff0002, CSC_RESP_OKAY);
			wr(CSC_OFS_SINGLE, 32'hffff0003, CSC_RESP_OKAY);
			if (i)
				rd(CSC_OFS_SINGLE, 32'h1, CSC_RESP_OKAY);
			repeat (80) @(posedge clk);
			chk("frames", 32'h1, 32'(nfr));
			rd(CSC_OFS_SINGLE, 32'h0, CSC_RESP_OKAY);
		end
		// Save a distinct working value into each user slot
		for (int s = 1; s < 4; s++) begin
			wr(CSC_OFS_SAVE_SLOT, 32'(s), CSC_RESP_OKAY);
			set_val <= 32'hc0de0000 + 32'(s);
			set_en <= 1'b1;
			@(posedge clk);
			set_en <= 1'b0;
			wr(CSC_OFS_SAVE, 32'h1, CSC_RESP_OKAY);
			rd(CSC_OFS_SAVE, 32'h0, CSC_RESP_OKAY);
		end
		wr(CSC_OFS_SAVE_SLOT, 32'h5, CSC_RESP_OKAY);
		rd(CSC_OFS_SAVE_SLOT, 32'h3, CSC_RESP_OKAY);
		for (int s = 0; s < 4; s++) begin
			wr(CSC_OFS_LOAD_SLOT, 32'(s), CSC_RESP_OKAY);
			repeat (3) @(posedge clk);
			chk("cfg_work", s ? 32'hc0de0000 + 32'(s) : DEF, cfg_work);
			rd(CSC_OFS_LOAD_SLOT, 32'(s), CSC_RESP_OKAY);
		end
		// Out-of-range load leaves everything alone
		nld = 0;
		wr(CSC_OFS_LOAD_SLOT, 32'h4, CSC_RESP_OKAY);
		repeat (4) @(posedge clk);
		chk("loads", 32'h0, 32'(nld));
		rd(CSC_OFS_LOAD_SLOT, 32'h3, CSC_RESP_OKAY);
		// Save to factory slot is refused
		wr(CSC_OFS_SAVE_SLOT, 32'h0, CSC_RESP_OKAY);
		wr(CSC_OFS_SAVE, 32'h1, CSC_RESP_OKAY);
		wr(CSC_OFS_LOAD_SLOT, 32'h0, CSC_RESP_OKAY);
		repeat (3) @(posedge clk);
		chk("factory", DEF, cfg_work);
		complete_run();
	end
endmodule

// ---- verilog/csc_axil_slave.sv ----
// AXI4-Lite slave front end: one write and one read in flight
`timescale 1ns/1ps
module csc_axil_slave
	import csc_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [csc_pkg::CSC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [csc_pkg::CSC_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [csc_pkg::CSC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [csc_pkg::CSC_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_en,
	output logic [csc_pkg::CSC_ADDR_W-1:0] wr_addr,
	output logic [csc_pkg::CSC_DATA_W-1:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_err,
	output logic rd_en,
	output logic [csc_pkg::CSC_ADDR_W-1:0] rd_addr,
	input wire logic [csc_pkg::CSC_DATA_W-1:0] rd_data,
	input wire logic rd_err
);
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [CSC_DATA_W-1:0] rdata;
		logic [1:0] rresp;
		logic aw_ok;
		logic w_ok;
		logic ar_ok;
		logic [CSC_ADDR_W-1:0] waddr;
		logic [CSC_DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic [CSC_ADDR_W-1:0] raddr;
	} csc_axi_state_t;

	csc_axi_state_t q, d;

	assign wr_en = q.aw_ok && q.w_ok && !q.bvalid;
	assign rd_en = q.ar_ok && !q.rvalid;

	always_comb begin
		d = q;
		if (s_axi_awvalid && q.awready) begin
			d.aw_ok = 1'b1;
			d.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_ok = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (wr_en) begin
			d.aw_ok = 1'b0;
			d.w_ok = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = wr_err ? CSC_RESP_SLVERR : CSC_RESP_OKAY;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		d.awready = !d.aw_ok && !d.bvalid;
		d.wready = !d.w_ok && !d.bvalid;
		if (s_axi_arvalid && q.arready) begin
			d.ar_ok = 1'b1;
			d.raddr = s_axi_araddr;
		end
		if (rd_en) begin
			d.ar_ok = 1'b0;
			d.rvalid = 1'b1;
			d.rdata = rd_data;
			d.rresp = rd_err ? CSC_RESP_SLVERR : CSC_RESP_OKAY;
		end
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		d.arready = !d.ar_ok && !d.rvalid;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign wr_addr = q.waddr;
	assign wr_data = q.wdata;
	assign wr_strb = q.wstrb;
	assign rd_addr = q.raddr;

endmodule

// ---- verilog/csc_ctrl.sv ----
// Capture and settings slot control: register group and transmit FSM
`timescale 1ns/1ps
module csc_ctrl
	import csc_pkg::*;
#(
	parameter int CFG_W = 32,
	parameter logic [CFG_W-1:0] CFG_DEFAULT = '0
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [csc_pkg::CSC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [csc_pkg::CSC_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [csc_pkg::CSC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [csc_pkg::CSC_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [csc_pkg::CSC_FMT_W-1:0] video_format,
	input wire logic frame_done,
	input wire logic [CFG_W-1:0] cfg_work,
	output logic stream_en,
	output logic frame_req,
	output logic cfg_load_valid,
	output logic [CFG_W-1:0] cfg_load_data
);
	import csc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		csc_tx_state_t fsm;
		logic cont;
		logic single;
		logic [CSC_SLOT_W-1:0] save_slot;
		logic [CSC_SLOT_W-1:0] cur_slot;
		logic stream_en;
		logic frame_req;
		logic load_pend;
		logic [CSC_SLOT_W-1:0] load_slot;
		logic load_valid;
		logic [CFG_W-1:0] load_data;
	} csc_ctrl_state_t;

	csc_ctrl_state_t q, d;

	logic wr_en;
	logic [CSC_ADDR_W-1:0] wr_addr;
	logic [CSC_DATA_W-1:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_err;
	logic rd_en;
	logic [CSC_ADDR_W-1:0] rd_addr;
	logic [CSC_DATA_W-1:0] rd_data;
	logic rd_err;
	logic fmt_ok;
	logic wr_lane0;
	logic wr_cont;
	logic wr_save;
	logic wr_single;
	logic wr_save_slot;
	logic wr_load_slot;
	logic mem_we;
	logic [CFG_W-1:0] mem_rdata;

	////////////////////////////////////////////////////////////////////////
	// Bus front end and slot storage

	csc_axil_slave u_bus (
		.clk(clk),
		.resetn(resetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	csc_slot_mem #(
		.CFG_W(CFG_W),
		.NUM_SLOTS(CSC_NUM_SLOTS),
		.CFG_DEFAULT(CFG_DEFAULT)
	) u_slots (
		.clk(clk),
		.resetn(resetn),
		.we(mem_we),
		.waddr(q.save_slot),
		.wdata(cfg_work),
		.raddr(q.load_slot),
		.rdata(mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// Write decode

	assign fmt_ok = csc_fmt_ok(video_format);
	assign wr_lane0 = wr_en && wr_strb[0];

	always_comb begin
		wr_cont = 1'b0;
		wr_save = 1'b0;
		wr_single = 1'b0;
		wr_save_slot = 1'b0;
		wr_load_slot = 1'b0;
		wr_err = 1'b0;
		case ({wr_addr[CSC_ADDR_W-1:2], 2'b00})
			CSC_OFS_CONT: wr_cont = wr_lane0;
			CSC_OFS_SAVE: wr_save = wr_lane0;
			CSC_OFS_SINGLE: wr_single = wr_lane0;
			CSC_OFS_SAVE_SLOT: wr_save_slot = wr_lane0;
			CSC_OFS_LOAD_SLOT: wr_load_slot = wr_lane0;
			default: wr_err = 1'b1;
		endcase
	end

	// Slot 0 is the factory set and never a save target
	assign mem_we = wr_save && wr_data[CSC_BIT_SAVE]
		&& (q.save_slot != CSC_SLOT_FACTORY);

	////////////////////////////////////////////////////////////////////////
	// Read decode

	always_comb begin
		rd_data = '0;
		rd_err = 1'b0;
		case ({rd_addr[CSC_ADDR_W-1:2], 2'b00})
			CSC_OFS_CONT: rd_data[CSC_BIT_CONT] = q.cont;
			CSC_OFS_SAVE: rd_data = '0;
			CSC_OFS_SINGLE: rd_data[CSC_BIT_SINGLE] = q.single;
			CSC_OFS_SAVE_SLOT:
				rd_data[CSC_SLOT_LSB +: CSC_SLOT_W] = q.save_slot;
			CSC_OFS_LOAD_SLOT:
				rd_data[CSC_SLOT_LSB +: CSC_SLOT_W] = q.cur_slot;
			default: rd_err = 1'b1;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		d = q;
		d.frame_req = 1'b0;
		d.load_valid = 1'b0;
		if (wr_cont) begin
			d.cont = wr_data[CSC_BIT_CONT];
		end
		// Only bit 0 matters; multi-frame bit and count ignored
		if (wr_single && wr_data[CSC_BIT_SINGLE] && fmt_ok && !q.single
			&& !q.cont && q.fsm == CSC_ST_IDLE) begin
			d.single = 1'b1;
		end
		if (wr_save_slot && csc_slot_ok(wr_data)) begin
			d.save_slot = wr_data[CSC_SLOT_LSB +: CSC_SLOT_W];
		end
		if (q.load_pend) begin
			d.load_pend = 1'b0;
			d.load_valid = 1'b1;
			d.load_data = mem_rdata;
			d.cur_slot = q.load_slot;
		end
		// New request wins over one that is finishing
		if (wr_load_slot && csc_slot_ok(wr_data)) begin
			d.load_pend = 1'b1;
			d.load_slot = wr_data[CSC_SLOT_LSB +: CSC_SLOT_W];
		end
		unique case (q.fsm)
			CSC_ST_IDLE: begin
				if (q.cont && fmt_ok) begin
					d.fsm = CSC_ST_STREAM;
				end else if (q.single) begin
					d.fsm = CSC_ST_SINGLE;
					d.frame_req = 1'b1;
				end
			end
			CSC_ST_STREAM: begin
				if (!q.cont || !fmt_ok) begin
					d.fsm = CSC_ST_IDLE;
				end
			end
			CSC_ST_SINGLE: begin
				if (frame_done) begin
					d.single = 1'b0;
					d.fsm = CSC_ST_IDLE;
				end
			end
			default: d.fsm = CSC_ST_IDLE;
		endcase
		d.stream_en = (d.fsm == CSC_ST_STREAM);
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			q <= '0;
			q.fsm <= CSC_ST_IDLE;
			q.cont <= CSC_RST_CONT;
			q.single <= CSC_RST_SINGLE;
			q.save_slot <= CSC_RST_SAVE_SLOT;
			q.cur_slot <= CSC_RST_LOAD_SLOT;
		end else begin
			q <= d;
		end
	end

	assign stream_en = q.stream_en;
	assign frame_req = q.frame_req;
	assign cfg_load_valid = q.load_valid;
	assign cfg_load_data = q.load_data;

	////////////////////////////////////////////////////////////////////////
	// Checks

	logic [1:0] req_cnt_q;

	always_ff @(posedge clk) begin
		if (!resetn || !q.single) begin
			req_cnt_q <= 2'h0;
		end else if (q.frame_req && req_cnt_q != 2'h3) begin
			req_cnt_q <= req_cnt_q + 2'h1;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	a_stream_start: assert property (
		wr_cont && wr_data[CSC_BIT_CONT] && q.fsm == CSC_ST_IDLE
			&& !q.single ##1 fmt_ok |-> ##1 stream_en
	) else $error("stream did not start");

	a_stream_stop: assert property (
		wr_cont && !wr_data[CSC_BIT_CONT] |-> ##2 !stream_en
	) else $error("stream did not stop");

	a_stream_fmt: assert property (
		stream_en |-> $past(fmt_ok) && $past(q.cont)
	) else $error("stream without allowed format");

	a_save_write: assert property (
		wr_save && wr_data[CSC_BIT_SAVE] && q.save_slot != 2'h0
			|-> mem_we
	) else $error("save request lost");

	a_save_refused: assert property (
		(q.save_slot == 2'h0 || !wr_save) |-> !mem_we
	) else $error("save to factory slot");

	a_trig_reads_zero: assert property (
		rd_en && {rd_addr[CSC_ADDR_W-1:2], 2'b00} == CSC_OFS_SAVE
			|-> rd_data == '0
	) else $error("save trigger does not read zero");

	a_single_clears: assert property (
		q.fsm == CSC_ST_SINGLE && frame_done
			|=> !q.single && q.fsm == CSC_ST_IDLE
	) else $error("single-frame bit not cleared");

	a_single_once: assert property (
		frame_req |-> $past(q.single) && req_cnt_q == 2'h0
	) else $error("more than one frame requested");

	a_multi_ignored: assert property (
		wr_single && !wr_data[CSC_BIT_SINGLE] && !frame_done
			|=> q.single == $past(q.single)
	) else $error("multi-frame fields had effect");

	a_single_start: assert property (
		wr_single && wr_data[CSC_BIT_SINGLE] && fmt_ok && !q.single
			&& !q.cont && q.fsm == CSC_ST_IDLE |=> q.single ##1 frame_req
	) else $error("single frame not started");

	a_frame_pulse: assert property (
		frame_req |=> !frame_req
	) else $error("frame request longer than one cycle");

	a_cont_write: assert property (
		wr_cont |=> q.cont == $past(wr_data[CSC_BIT_CONT])
	) else $error("continuous bit not written");

	a_slot_keep: assert property (
		wr_save_slot && !csc_slot_ok(wr_data) |=> $stable(q.save_slot)
	) else $error("out-of-range save slot stored");

	a_load_copy: assert property (
		wr_load_slot && csc_slot_ok(wr_data)
			|-> ##2 cfg_load_valid
			&& q.cur_slot == $past(wr_data[1:0], 2)
	) else $error("load did not copy slot");

	a_load_refused: assert property (
		wr_load_slot && !csc_slot_ok(wr_data) && !q.load_pend
			|=> !q.load_pend ##1 !cfg_load_valid && $stable(q.cur_slot)
	) else $error("out-of-range load acted");

	c_stream: cover property (q.fsm == CSC_ST_IDLE ##1 stream_en);
	c_single: cover property (frame_req ##[1:20] !q.single);
	c_load: cover property (cfg_load_valid && q.cur_slot == 2'h3);
	c_save: cover property (mem_we && q.save_slot == 2'h2);
	c_multi: cover property (wr_single && !wr_data[CSC_BIT_SINGLE]);

endmodule

// ---- verilog/csc_pkg.sv ----
// Package: register map, field layout, reset values and state codes
package csc_pkg;

	localparam int CSC_ADDR_W = 12;
	localparam int CSC_DATA_W = 32;
	localparam int CSC_SLOT_W = 2;
	localparam int CSC_NUM_SLOTS = 4;
	localparam int CSC_FMT_W = 3;

	localparam logic [11:0] CSC_OFS_CONT = 12'h614;
	localparam logic [11:0] CSC_OFS_SAVE = 12'h618;
	localparam logic [11:0] CSC_OFS_SINGLE = 12'h61c;
	localparam logic [11:0] CSC_OFS_SAVE_SLOT = 12'h620;
	localparam logic [11:0] CSC_OFS_LOAD_SLOT = 12'h624;

	localparam int CSC_BIT_CONT = 0;
	localparam int CSC_BIT_SAVE = 0;
	localparam int CSC_BIT_SINGLE = 0;
	localparam int CSC_BIT_MULTI = 1;
	localparam int CSC_CNT_LSB = 16;
	localparam int CSC_SLOT_LSB = 0;

	localparam logic CSC_RST_CONT = 1'b0;
	localparam logic CSC_RST_SINGLE = 1'b0;
	localparam logic [1:0] CSC_RST_SAVE_SLOT = 2'h1;
	localparam logic [1:0] CSC_RST_LOAD_SLOT = 2'h0;

	localparam logic [2:0] CSC_FMT_ZERO = 3'h0;
	localparam logic [2:0] CSC_FMT_SEVEN = 3'h7;
	localparam logic [1:0] CSC_SLOT_FACTORY = 2'h0;

	localparam logic [1:0] CSC_RESP_OKAY = 2'h0;
	localparam logic [1:0] CSC_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		CSC_ST_IDLE = 3'b001,
		CSC_ST_STREAM = 3'b010,
		CSC_ST_SINGLE = 3'b100
	} csc_tx_state_t;

	// Transmission allowed only in format 0 or format 7
	function automatic logic csc_fmt_ok(input logic [2:0] fmt);
		return (fmt == CSC_FMT_ZERO) || (fmt == CSC_FMT_SEVEN);
	endfunction

	// Slot number fits in the slot field, upper bits all zero
	function automatic logic csc_slot_ok(input logic [31:0] val);
		return val[31:CSC_SLOT_W] == '0;
	endfunction

endpackage

// ---- verilog/csc_slot_mem.sv ----
// Settings slots: one factory slot and user slots, held in flops
`timescale 1ns/1ps
module csc_slot_mem #(
	parameter int CFG_W = 32,
	parameter int NUM_SLOTS = 4,
	parameter logic [CFG_W-1:0] CFG_DEFAULT = '0
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic we,
	input wire logic [1:0] waddr,
	input wire logic [CFG_W-1:0] wdata,
	input wire logic [1:0] raddr,
	output logic [CFG_W-1:0] rdata
);
	typedef struct packed {
		logic [NUM_SLOTS-1:0][CFG_W-1:0] slot;
	} csc_mem_state_t;

	csc_mem_state_t q, d;

	always_comb begin
		d = q;
		if (we) begin
			d.slot[waddr] = wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			q <= {NUM_SLOTS{CFG_DEFAULT}};
		end else begin
			q <= d;
		end
	end

	assign rdata = q.slot[raddr];

endmodule
